/* cpr_pkg.sv */
// Shared constants for the commutation phase reference block
package cpr_pkg;
    // Register byte offsets
    localparam logic [7:0] hall_setup_off = 8'h00;
    localparam logic [7:0] ctrl_off = 8'h04;
    localparam logic [7:0] phase_pos_off = 8'h08;
    localparam logic [7:0] stored_off_off = 8'h0c;
    localparam logic [7:0] adv_gain_off = 8'h10;
    localparam logic [7:0] mag_off = 8'h14;
    localparam logic [7:0] slip_off = 8'h18;
    localparam logic [7:0] band_off = 8'h1c;
    localparam logic [7:0] velocity_off = 8'h20;
    localparam logic [7:0] ferr_off = 8'h24;
    localparam logic [7:0] torque_off = 8'h28;
    localparam logic [7:0] status_off = 8'h2c;
    localparam logic [7:0] flag_reg_off = 8'h30;
    localparam logic [7:0] rotor_off = 8'h34;
    localparam logic [7:0] angle_off = 8'h38;
    // Hall reference setup fields and hall flag word bits
    localparam int hall_mode_bit = 23;
    localparam int dir_bit = 22;
    localparam int offset_lsb = 16;
    localparam int offset_msb = 21;
    localparam int u_bit = 22;
    localparam int v_bit = 21;
    localparam int w_bit = 20;
    localparam int addr_msb = 15;
    // Control register fields
    localparam int ctl_pon_bit = 0;
    localparam int ctl_reset_cmd_bit = 1;
    localparam int ctl_induction_bit = 2;
    // Slip scaling exponent: rotor angle carries 38 fraction bits per cycle
    localparam int slip_shift = 38;
    localparam int acc_w = 62;
    // Phase update tick: 20 MHz / 9040 Hz
    localparam int clk_hz = 20000000;
    localparam int update_hz = 9040;
    localparam int tick_cycles = clk_hz / update_hz;
    localparam logic [11:0] tick_last = 12'(tick_cycles - 1);
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_ref = 2'b01,
        st_run = 2'b10
    } phase_state_t;
endpackage

/* commutation_phase_reference.sv */
// Commutation phase reference, phase advance and induction slip logic
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module commutation_phase_reference (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [23:0] flag_bank_0,
    input wire logic [23:0] flag_bank_1,
    input wire logic [23:0] flag_bank_2,
    input wire logic [23:0] flag_bank_3,
    output logic [23:0] commutation_angle,
    output logic [23:0] magnetization_current_out,
    output logic [23:0] torque_current_out,
    output logic in_position_flag,
    output logic hall_fault,
    output logic phase_update_tick
);
    /////////////////////////////////////////////////////////////////
    logic [23:0] hall_reference_setup_reg;
    logic [2:0] ctrl_reg;
    logic [23:0] phase_position_word_reg;
    logic [23:0] stored_phase_offset_reg;
    logic [23:0] velocity_advance_gain_reg;
    logic [23:0] magnetization_current_reg;
    logic [23:0] slip_gain_reg;
    logic [23:0] in_position_band_reg;
    logic [23:0] velocity_reg;
    logic [23:0] following_error_reg;
    logic [23:0] torque_cmd_reg;
    localparam int acc_w_l = cpr_pkg::acc_w;
    logic [acc_w_l-1:0] rotor_angle_reg;
    logic [11:0] tick_cnt_reg;
    logic [2:0] hall_s1_reg, hall_s2_reg, hall_s3_reg, hall_reg;
    logic ref_pending_reg;
    logic hall_mode_reg;
    logic [23:0] angle_reg;
    cpr_pkg::phase_state_t state_reg;

    logic wr_en, rd_en, tick;
    logic [23:0] sel_flags;
    logic [2:0] hall_raw;
    logic [2:0] sector;
    logic sector_valid;
    logic [23:0] hall_phase;
    logic [47:0] adv_prod;
    logic [23:0] adv_term;
    logic [47:0] slip_prod;
    logic [23:0] elec_angle;

    // Strict APB: access only when both strobes are up
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= cpr_pkg::angle_off) && (a[1:0] == 2'b00);
    endfunction

    // Motor reset command: a ctrl write with the command bit set
    function automatic logic reset_cmd(input logic w, input logic [7:0] a, input logic [31:0] d);
        reset_cmd = w && (a == cpr_pkg::ctrl_off) && d[cpr_pkg::ctl_reset_cmd_bit];
    endfunction

    /////////////////////////////////////////////////////////////////
    // Phase update tick
    // Integer divide drops a fraction of a clock, so updates run a hair fast
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 12'h000;
        end else if (tick_cnt_reg == cpr_pkg::tick_last) begin
            tick_cnt_reg <= 12'h000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 12'h001;
        end
    end
    assign tick = (tick_cnt_reg == cpr_pkg::tick_last);
    assign phase_update_tick = tick;

    /////////////////////////////////////////////////////////////////
    // Hall source select and synchroniser
    always_comb begin
        case (hall_reference_setup_reg[1:0])
            2'b00: sel_flags = flag_bank_0;
            2'b01: sel_flags = flag_bank_1;
            2'b10: sel_flags = flag_bank_2;
            default: sel_flags = flag_bank_3;
        endcase
    end
    assign hall_raw = {sel_flags[cpr_pkg::u_bit], sel_flags[cpr_pkg::v_bit], sel_flags[cpr_pkg::w_bit]};

    // Pins are asynchronous; accept a change once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hall_s1_reg <= 3'h0;
            hall_s2_reg <= 3'h0;
            hall_s3_reg <= 3'h0;
            hall_reg <= 3'h0;
        end else begin
            hall_s1_reg <= hall_raw;
            hall_s2_reg <= hall_s1_reg;
            hall_s3_reg <= hall_s2_reg;
            if (hall_s2_reg == hall_s3_reg) begin
                hall_reg <= hall_s3_reg;
            end
        end
    end

    /////////////////////////////////////////////////////////////////
    // Sector decode; relies on halls at 50% duty, 120 deg apart
    always_comb begin
        sector_valid = 1'b1;
        case (hall_reg)
            3'b011: sector = 3'd0; // First state after V rose with U low
            3'b010: sector = 3'd1;
            3'b110: sector = 3'd2;
            3'b100: sector = 3'd3;
            3'b101: sector = 3'd4;
            3'b001: sector = 3'd5;
            default: begin
                sector = 3'd0;
                sector_valid = 1'b0;
            end
        endcase
    end

    // Sector centre in 1/64 units, reversed sense mirrors it, then offset
    always_comb begin
        logic [5:0] base;
        logic [5:0] pos;
        pos = 6'h00;
        // Sector centres rounded down to whole 1/64 steps
        base = 6'((32'(sector) * 64 + 32) / 6);
        if (hall_reference_setup_reg[cpr_pkg::dir_bit]) begin
            pos = 6'd0 - base;
        end else begin
            pos = base;
        end
        pos = pos + hall_reference_setup_reg[cpr_pkg::offset_msb:cpr_pkg::offset_lsb];
        hall_phase = {pos, 18'h00000};
    end

    /////////////////////////////////////////////////////////////////
    // Reference sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= cpr_pkg::st_idle;
            ref_pending_reg <= 1'b1;
        end else begin
            case (state_reg)
                cpr_pkg::st_idle: begin
                    // Power-on enable clears at reset, so the reset-time
                    // reference waits here until firmware reloads it
                    if (ctrl_reg[cpr_pkg::ctl_pon_bit] && ref_pending_reg) begin
                        state_reg <= cpr_pkg::st_ref;
                        ref_pending_reg <= 1'b0;
                    end else if (reset_cmd(wr_en, paddr, pwdata)) begin
                        state_reg <= cpr_pkg::st_ref;
                        ref_pending_reg <= 1'b0;
                    end
                end
                cpr_pkg::st_ref: begin
                    // Reference lands on the next update tick
                    if (tick) begin
                        state_reg <= cpr_pkg::st_run;
                    end
                end
                cpr_pkg::st_run: begin
                    if (reset_cmd(wr_en, paddr, pwdata)) begin
                        state_reg <= cpr_pkg::st_ref;
                    end
                end
                default: state_reg <= cpr_pkg::st_idle;
            endcase
        end
    end

    /////////////////////////////////////////////////////////////////
    // Configuration words; the ctrl command bit is a strobe, never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hall_reference_setup_reg <= 24'h000000;
            ctrl_reg <= 3'h0;
            stored_phase_offset_reg <= 24'h000000;
            velocity_advance_gain_reg <= 24'h000000;
            magnetization_current_reg <= 24'h000000;
            slip_gain_reg <= 24'h000000;
            in_position_band_reg <= 24'h000000;
        end else if (wr_en) begin
            case (paddr)
                cpr_pkg::hall_setup_off: hall_reference_setup_reg <= pwdata[23:0];
                cpr_pkg::ctrl_off: ctrl_reg <= {pwdata[cpr_pkg::ctl_induction_bit], 1'b0, pwdata[cpr_pkg::ctl_pon_bit]};
                cpr_pkg::stored_off_off: stored_phase_offset_reg <= pwdata[23:0];
                cpr_pkg::adv_gain_off: velocity_advance_gain_reg <= pwdata[23:0];
                cpr_pkg::mag_off: magnetization_current_reg <= pwdata[23:0];
                cpr_pkg::slip_off: slip_gain_reg <= pwdata[23:0];
                cpr_pkg::band_off: in_position_band_reg <= pwdata[23:0];
                default: ;
            endcase
        end
    end

    // Servo-loop words, rewritten by firmware every servo cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            velocity_reg <= 24'h000000;
            following_error_reg <= 24'h000000;
            torque_cmd_reg <= 24'h000000;
        end else if (wr_en) begin
            case (paddr)
                cpr_pkg::velocity_off: velocity_reg <= pwdata[23:0];
                cpr_pkg::ferr_off: following_error_reg <= pwdata[23:0];
                cpr_pkg::torque_off: torque_cmd_reg <= pwdata[23:0];
                default: ;
            endcase
        end
    end

    // Phase position: hall or stored offset load at reference; a software write in the same cycle wins over it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_position_word_reg <= 24'h000000;
            hall_mode_reg <= 1'b0;
        end else if (wr_en && paddr == cpr_pkg::phase_pos_off) begin
            phase_position_word_reg <= pwdata[23:0];
        end else if (state_reg == cpr_pkg::st_ref && tick) begin
            hall_mode_reg <= hall_reference_setup_reg[cpr_pkg::hall_mode_bit];
            if (hall_reference_setup_reg[cpr_pkg::hall_mode_bit] && sector_valid) begin
                phase_position_word_reg <= hall_phase;
            end else if (!hall_reference_setup_reg[cpr_pkg::hall_mode_bit]) begin
                phase_position_word_reg <= stored_phase_offset_reg;
            end
        end
    end

    /////////////////////////////////////////////////////////////////
    // Angle math; the product is truncated to the angle width on purpose
    // Rotor angle keeps its fraction bits so a small slip still accumulates
    assign adv_prod = 48'($signed(velocity_reg) * $signed(velocity_advance_gain_reg));
    assign adv_term = hall_mode_reg ? 24'h000000 : adv_prod[23:0];
    assign slip_prod = 48'($signed(slip_gain_reg) * $signed(torque_cmd_reg));
    assign elec_angle = phase_position_word_reg + adv_term;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rotor_angle_reg <= '0;
        end else if (tick && ctrl_reg[cpr_pkg::ctl_induction_bit]) begin
            // Low bits hold 2^-38 cycle units per DAC bit
            rotor_angle_reg <= rotor_angle_reg + acc_w_l'($signed(slip_prod));
        end
    end

    // Drive outputs move only on the update tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angle_reg <= 24'h000000;
            magnetization_current_out <= 24'h000000;
            torque_current_out <= 24'h000000;
        end else if (tick) begin
            if (ctrl_reg[cpr_pkg::ctl_induction_bit]) begin
                angle_reg <= elec_angle + rotor_angle_reg[acc_w_l-1:cpr_pkg::slip_shift];
                magnetization_current_out <= magnetization_current_reg;
            end else begin
                angle_reg <= elec_angle;
                magnetization_current_out <= 24'h000000;
            end
            torque_current_out <= torque_cmd_reg;
        end
    end

    // Only meaningful once a reference has run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_position_flag <= 1'b0;
        end else begin
            in_position_flag <= (state_reg == cpr_pkg::st_run) &&
                ($signed(following_error_reg) < $signed(in_position_band_reg)) &&
                ($signed(following_error_reg) > -$signed(in_position_band_reg));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hall_fault <= 1'b0;
        end else begin
            hall_fault <= hall_reference_setup_reg[cpr_pkg::hall_mode_bit] && !sector_valid;
        end
    end
    assign commutation_angle = angle_reg;

    /////////////////////////////////////////////////////////////////
    // Read mux; unmapped reads return zero
    always_comb begin
        prdata = 32'h00000000;
        if (rd_en && mapped(paddr)) begin
            case (paddr)
                cpr_pkg::hall_setup_off: prdata = {8'h00, hall_reference_setup_reg};
                cpr_pkg::ctrl_off: prdata = {29'h0, ctrl_reg};
                cpr_pkg::phase_pos_off: prdata = {8'h00, phase_position_word_reg};
                cpr_pkg::stored_off_off: prdata = {8'h00, stored_phase_offset_reg};
                cpr_pkg::adv_gain_off: prdata = {8'h00, velocity_advance_gain_reg};
                cpr_pkg::mag_off: prdata = {8'h00, magnetization_current_reg};
                cpr_pkg::slip_off: prdata = {8'h00, slip_gain_reg};
                cpr_pkg::band_off: prdata = {8'h00, in_position_band_reg};
                cpr_pkg::velocity_off: prdata = {8'h00, velocity_reg};
                cpr_pkg::ferr_off: prdata = {8'h00, following_error_reg};
                cpr_pkg::torque_off: prdata = {8'h00, torque_cmd_reg};
                cpr_pkg::status_off: prdata = {24'h0, hall_fault, sector_valid, sector, state_reg, in_position_flag};
                cpr_pkg::flag_reg_off: prdata = {29'h0, hall_reg};
                cpr_pkg::rotor_off: prdata = {8'h00, rotor_angle_reg[acc_w_l-1:cpr_pkg::slip_shift]};
                default: prdata = {8'h00, angle_reg};
            endcase
        end
    end
endmodule

/* cpr_checker.sv */
// Port-level assertion checker for the commutation phase reference block
`timescale 1ns/1ns
module cpr_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [23:0] commutation_angle,
    input wire logic [23:0] magnetization_current_out,
    input wire logic [23:0] torque_current_out,
    input wire logic in_position_flag,
    input wire logic hall_fault,
    input wire logic phase_update_tick
);
    logic [11:0] tick_gap;
    logic tick_seen;
    logic induction_m;
    logic [23:0] setup_m, band_m, ferr_m;
    wire logic wr = psel && penable && pwrite;
    wire logic [23:0] ferr_abs = ferr_m[23] ? -ferr_m : ferr_m;
    wire logic inpos_ok = ferr_abs < band_m;
    ////////////////////////////////////////////////////////////////////////
    // Cycles since last tick; first tick ignored as the phase is unknown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_gap <= 12'h000;
            tick_seen <= 1'b0;
        end else begin
            tick_gap <= phase_update_tick ? 12'h000 : tick_gap + 12'h001;
            tick_seen <= tick_seen | phase_update_tick;
        end
    end
    // Shadow copies of registers written over the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            induction_m <= 1'b0;
            setup_m <= 24'h000000;
            band_m <= 24'h000000;
            ferr_m <= 24'h000000;
        end else if (wr) begin
            induction_m <= (paddr == cpr_pkg::ctrl_off) ? pwdata[cpr_pkg::ctl_induction_bit] : induction_m;
            setup_m <= (paddr == cpr_pkg::hall_setup_off) ? pwdata[23:0] : setup_m;
            band_m <= (paddr == cpr_pkg::band_off) ? pwdata[23:0] : band_m;
            ferr_m <= (paddr == cpr_pkg::ferr_off) ? pwdata[23:0] : ferr_m;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && penable |-> pready && !pslverr; endproperty
    a_ready: assert property (p_ready) else $error("bus access not completed cleanly");
    property p_rd_idle; !(psel && penable && !pwrite) |-> prdata == 32'h00000000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read access");
    property p_rd_width; prdata[31:24] == 8'h00; endproperty
    a_rd_width: assert property (p_rd_width) else $error("read data above bit 23");
    property p_tick; phase_update_tick && tick_seen |-> tick_gap == 12'(cpr_pkg::tick_cycles - 1); endproperty
    a_tick: assert property (p_tick) else $error("update tick spacing wrong");
    property p_fault; hall_fault |-> $past(setup_m[23]); endproperty
    a_fault: assert property (p_fault) else $error("hall fault outside hall mode");
    property p_angle; $changed(commutation_angle) |-> $past(phase_update_tick); endproperty
    a_angle: assert property (p_angle) else $error("angle moved off tick");
    property p_torque; $changed(torque_current_out) |-> $past(phase_update_tick); endproperty
    a_torque: assert property (p_torque) else $error("torque moved off tick");
    property p_mag; $changed(magnetization_current_out) && magnetization_current_out != 24'h000000
        |-> $past(induction_m); endproperty
    a_mag: assert property (p_mag) else $error("magnetization without induction");
    property p_inpos; in_position_flag |-> $past(inpos_ok); endproperty
    a_inpos: assert property (p_inpos) else $error("in position with large error");
endmodule
bind commutation_phase_reference cpr_checker i_cpr_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .commutation_angle(commutation_angle), .magnetization_current_out(magnetization_current_out),
    .torque_current_out(torque_current_out), .in_position_flag(in_position_flag), .hall_fault(hall_fault),
    .phase_update_tick(phase_update_tick));

/* hall_sensor_model.sv */
// Behavioural hall sensor set feeding one flag word
`timescale 1ns/1ns
module hall_sensor_model (
    input wire logic [2:0] elec_pos,
    input wire logic [1:0] fault_mode,
    output logic [23:0] flag_word
);
    logic [2:0] uvw;
    // Each sensor high for three of six steps, two steps apart
    always_comb begin
        uvw[2] = (elec_pos >= 3'd2) && (elec_pos <= 3'd4);
        uvw[1] = elec_pos <= 3'd2;
        uvw[0] = (elec_pos >= 3'd4) || (elec_pos == 3'd0);
        flag_word = 24'h000000;
        flag_word[22:20] = (fault_mode == 2'd1) ? 3'b000 : ((fault_mode == 2'd2) ? 3'b111 : uvw);
    end
endmodule

/* commutation_phase_reference_bench.sv */
// Self-checking bench for the commutation phase reference block
`timescale 1ns/1ns
module commutation_phase_reference_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, p0;
    logic pready, pslverr, in_position_flag, hall_fault, phase_update_tick;
    logic [23:0] bank1, commutation_angle, mag_out, torque_out;
    logic [2:0] elec_pos = 3'd1;
    logic [1:0] fault_mode = 2'd0;
    logic [31:0] ferr_tab [4] = '{32'd50, 32'd100, 32'd150, 32'h00ffffce};
    int failures = 0;
    int checks_done = 0;
    always #25 pclk = ~pclk;
    hall_sensor_model i_hall_sensor_model (.elec_pos(elec_pos), .fault_mode(fault_mode), .flag_word(bank1));
    // Unused banks show an invalid hall state, so a wrong bank choice faults
    commutation_phase_reference i_commutation_phase_reference (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flag_bank_0(24'h700000), .flag_bank_1(bank1), .flag_bank_2(24'h700000),
        .flag_bank_3(24'h700000), .commutation_angle(commutation_angle), .magnetization_current_out(mag_out),
        .torque_current_out(torque_out), .in_position_flag(in_position_flag), .hall_fault(hall_fault),
        .phase_update_tick(phase_update_tick));
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) failures++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_tick(input int k);
        int n;
        repeat (k) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (phase_update_tick !== 1'b1 && n < 3000);
            if (phase_update_tick !== 1'b1) failures++;
        end
        repeat (3) @(posedge pclk);
    endtask
    // Reference through the reset command, then read back phase position
    task automatic href(input logic [31:0] setup, input logic [31:0] stored);
        apb(1'b1, cpr_pkg::stored_off_off, stored);
        apb(1'b1, cpr_pkg::hall_setup_off, setup);
        apb(1'b1, cpr_pkg::ctrl_off, 32'h00000002);
        wait_tick(1);
        apb(1'b0, cpr_pkg::phase_pos_off, 32'h00000000);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, cpr_pkg::phase_pos_off, 32'hffabcdef);
        apb(1'b0, cpr_pkg::phase_pos_off, 32'h00000000);
        chk("phase_pos", 32'h00abcdef, rd);
        apb(1'b1, 8'h3c, 32'h12345678);
        apb(1'b0, 8'h3c, 32'h00000000);
        chk("unmapped", 32'h00000000, rd);
        $display("test registers done");
        apb(1'b1, cpr_pkg::hall_setup_off, 32'h00800001);
        for (int i = 0; i < 8; i++) begin
            fault_mode <= (i < 6) ? 2'd0 : 2'(i - 5);
            elec_pos <= 3'(i % 6);
            repeat (8) @(posedge pclk);
            chk("hall_fault", {31'h0, i > 5}, {31'h0, hall_fault});
        end
        fault_mode <= 2'd0;
        elec_pos <= 3'd1;
        $display("test hall decode done");
        apb(1'b1, cpr_pkg::velocity_off, 32'h00000005);
        apb(1'b1, cpr_pkg::adv_gain_off, 32'h00000003);
        href(32'h00800001, 32'h00000000);
        p0 = rd;
        chk("hall_zero", 32'h00400000, p0);
        wait_tick(1);
        chk("angle_hall", p0, {8'h00, commutation_angle});
        href(32'h00850001, 32'h00123456);
        chk("offset", (p0 + 32'h00140000) & 32'h00ffffff, rd);
        href(32'h00c00001, 32'h00000000);
        chk("reversed", (-p0) & 32'h00ffffff, rd);
        href(32'h00000000, 32'h00100000);
        chk("stored", 32'h00100000, rd);
        wait_tick(1);
        chk("angle_adv", 32'h0010000f, {8'h00, commutation_angle});
        $display("test phase reference done");
        apb(1'b1, cpr_pkg::band_off, 32'd100);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, cpr_pkg::ferr_off, ferr_tab[i]);
            repeat (3) @(posedge pclk);
            chk("in_position", {31'h0, i == 0 || i == 3}, {31'h0, in_position_flag});
        end
        $display("test in position done");
        apb(1'b1, cpr_pkg::mag_off, 32'h00001234);
        apb(1'b1, cpr_pkg::torque_off, 32'h00000777);
        apb(1'b1, cpr_pkg::slip_off, 32'h00000aee);
        wait_tick(2);
        chk("mag_off", 32'h00000000, {8'h00, mag_out});
        apb(1'b1, cpr_pkg::ctrl_off, 32'h00000004);
        wait_tick(2);
        chk("mag_on", 32'h00001234, {8'h00, mag_out});
        chk("torque", 32'h00000777, {8'h00, torque_out});
        // Slip times torque of exactly one cycle unit steps the rotor word by one
        apb(1'b1, cpr_pkg::slip_off, 32'h00400000);
        apb(1'b1, cpr_pkg::torque_off, 32'h00010000);
        apb(1'b0, cpr_pkg::rotor_off, 32'h00000000);
        p0 = rd;
        wait_tick(1);
        apb(1'b0, cpr_pkg::rotor_off, 32'h00000000);
        chk("rotor_step", (p0 + 32'h00000001) & 32'h00ffffff, rd);
        $display("test induction done");
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, cpr_pkg::hall_setup_off, 32'h00800001);
        apb(1'b1, cpr_pkg::ctrl_off, 32'h00000001);
        wait_tick(2);
        apb(1'b0, cpr_pkg::phase_pos_off, 32'h00000000);
        chk("power_on_ref", 32'h00400000, rd);
        $display("test power-on reference done");
        print_verdict();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        print_verdict();
    end
endmodule
